// ---- logic/dbs_pkg.sv ----
// Constants for the descriptor base and status register bank
package dbs_pkg;
  localparam int DBS_ADDR_W = 8;
  localparam logic [DBS_ADDR_W-1:0] DBS_RX_BASE_OFS = 8'h18;
  localparam logic [DBS_ADDR_W-1:0] DBS_TX_BASE_OFS = 8'h20;
  localparam logic [DBS_ADDR_W-1:0] DBS_STATUS_OFS = 8'h28;
  localparam logic [DBS_ADDR_W-1:0] DBS_MASK_OFS = 8'h38;
  // Event bit positions inside the status register
  localparam int DBS_EVT_W = 14;
  localparam int DBS_B_TX_DONE = 0;
  localparam int DBS_B_TX_STOP = 1;
  localparam int DBS_B_TX_BUF = 2;
  localparam int DBS_B_JABBER = 3;
  localparam int DBS_B_UNDERFLOW = 5;
  localparam int DBS_B_RX_DONE = 6;
  localparam int DBS_B_RX_BUF = 7;
  localparam int DBS_B_RX_STOP = 8;
  localparam int DBS_B_RX_WDOG = 9;
  localparam int DBS_B_EARLY_TX = 10;
  localparam int DBS_B_TIMER = 11;
  localparam int DBS_B_FATAL = 13;
  // Summary and field positions
  localparam int DBS_B_ABN_SUM = 15;
  localparam int DBS_B_NRM_SUM = 16;
  localparam int DBS_RS_LO = 17;
  localparam int DBS_TS_LO = 20;
  localparam int DBS_EB_LO = 23;
  localparam logic [DBS_EVT_W-1:0] DBS_NORMAL_SET = 14'h0845;
  localparam logic [DBS_EVT_W-1:0] DBS_ABNORMAL_SET = 14'h27AA;
  localparam logic [DBS_EVT_W-1:0] DBS_EVT_USED = 14'h2FEF;
  // Reset values and response codes
  localparam logic [DBS_EVT_W-1:0] DBS_MASK_RESET = 14'h3FFF;
  localparam logic [31:0] DBS_BASE_RESET = 32'h00000000;
  localparam logic [2:0] DBS_PROC_STOPPED = 3'h0;
  localparam logic [1:0] DBS_RESP_OKAY = 2'h0;
  localparam logic [1:0] DBS_RESP_DECERR = 2'h3;
endpackage

// ---- logic/dbs_regs.sv ----
// Descriptor list base registers, event status register and its mask, behind an AXI4-Lite slave
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module dbs_regs
#(
  parameter int ADDR_W = dbs_pkg::DBS_ADDR_W
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_complete,
  input wire logic tx_stopped,
  input wire logic tx_buf_unavail,
  input wire logic tx_poll_empty,
  input wire logic tx_jabber,
  input wire logic tx_underflow,
  input wire logic tx_fifo_loaded,
  input wire logic rx_complete,
  input wire logic rx_desc_host_owned,
  input wire logic rx_desc_device_owned,
  input wire logic rx_watchdog,
  input wire logic timer_expired,
  input wire logic sys_error,
  input wire logic [2:0] sys_error_kind,
  input wire logic [2:0] tx_state,
  input wire logic [2:0] rx_state,
  output logic [31:2] rx_list_start,
  output logic [31:2] tx_list_start,
  output logic bus_halt,
  output logic host_irq
);
  import dbs_pkg::*;
  default clocking dbs_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  if (ADDR_W < 6 || ADDR_W > 32)
  begin : g_chk
    $error("dbs_regs: ADDR_W must cover offset 0x38 and fit 32 bits");
  end

  logic [31:0] receive_list_base;
  logic [31:0] transmit_list_base;
  logic [DBS_EVT_W-1:0] evt;
  logic [DBS_EVT_W-1:0] evt_mask;
  logic [2:0] error_type_field;
  logic [2:0] rx_state_q;
  logic rx_prev_dev_owned;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_full;
  logic w_full;
  logic wr_go;
  logic [31:0] bmask;
  logic [DBS_EVT_W-1:0] evt_set;
  logic [DBS_EVT_W-1:0] evt_clr;
  logic [DBS_EVT_W-1:0] next_evt;
  logic normal_summary;
  logic abnormal_summary;
  logic rx_enter_stop;
  logic [31:0] status_word;

  // Byte-lane mask built from the held strobes
  assign bmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  assign wr_go = aw_full && w_full && !s_axi_bvalid;
  // Write address and data are taken in either order and held until the response is accepted
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr <= s_axi_awaddr;
        aw_full <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_full <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Write response one cycle after both halves are held; unmapped offsets answer DECERR
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= DBS_RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr == DBS_RX_BASE_OFS || aw_addr == DBS_TX_BASE_OFS)
        s_axi_bresp <= DBS_RESP_OKAY;
      else if (aw_addr == DBS_STATUS_OFS || aw_addr == DBS_MASK_OFS)
        s_axi_bresp <= DBS_RESP_OKAY;
      else
        s_axi_bresp <= DBS_RESP_DECERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // List base registers; software is trusted to write them only while the process is stopped
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      receive_list_base <= DBS_BASE_RESET;
      transmit_list_base <= DBS_BASE_RESET;
    end
    else if (wr_go && aw_addr == DBS_RX_BASE_OFS)
      receive_list_base <= (receive_list_base & ~bmask) | (w_data & bmask);
    else if (wr_go && aw_addr == DBS_TX_BASE_OFS)
      transmit_list_base <= (transmit_list_base & ~bmask) | (w_data & bmask);
  end

  // Only bits 31:2 point at the lists; bits 1:0 are kept for readback but never used
  assign rx_list_start = receive_list_base[31:2];
  assign tx_list_start = transmit_list_base[31:2];
  // Mask register: a set bit keeps the event out of both summaries
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      evt_mask <= DBS_MASK_RESET;
    else if (wr_go && aw_addr == DBS_MASK_OFS)
      evt_mask <= (evt_mask & ~bmask[DBS_EVT_W-1:0]) | (w_data[DBS_EVT_W-1:0] & bmask[DBS_EVT_W-1:0]);
  end

  // Receive process stop detection and descriptor ownership history
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_state_q <= DBS_PROC_STOPPED;
      rx_prev_dev_owned <= 1'b1;
    end
    else
    begin
      rx_state_q <= rx_state;
      if (rx_desc_device_owned)
        rx_prev_dev_owned <= 1'b1;
      else if (rx_desc_host_owned)
        rx_prev_dev_owned <= 1'b0;
    end
  end

  assign rx_enter_stop = (rx_state == DBS_PROC_STOPPED) && (rx_state_q != DBS_PROC_STOPPED);
  // Event sources gathered into one set vector
  always_comb
  begin
    evt_set = '0;
    evt_set[DBS_B_TX_DONE] = tx_complete;
    evt_set[DBS_B_TX_STOP] = tx_stopped;
    evt_set[DBS_B_TX_BUF] = tx_buf_unavail && !tx_poll_empty;
    evt_set[DBS_B_JABBER] = tx_jabber;
    evt_set[DBS_B_UNDERFLOW] = tx_underflow;
    evt_set[DBS_B_RX_DONE] = rx_complete;
    evt_set[DBS_B_RX_BUF] = rx_desc_host_owned && rx_prev_dev_owned;
    evt_set[DBS_B_RX_STOP] = rx_enter_stop;
    evt_set[DBS_B_RX_WDOG] = rx_watchdog;
    evt_set[DBS_B_EARLY_TX] = tx_fifo_loaded;
    evt_set[DBS_B_TIMER] = timer_expired;
    evt_set[DBS_B_FATAL] = sys_error;
  end

  // Clears from software ones and from transmit completion; a set in the same cycle wins
  always_comb
  begin
    evt_clr = '0;
    if (wr_go && aw_addr == DBS_STATUS_OFS)
      evt_clr = w_data[DBS_EVT_W-1:0] & bmask[DBS_EVT_W-1:0];
    evt_clr[DBS_B_EARLY_TX] = evt_clr[DBS_B_EARLY_TX] | tx_complete;
    next_evt = ((evt & ~evt_clr) | evt_set) & DBS_EVT_USED;
  end

  // Sticky event bits; reads have no side effect on them
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      evt <= '0;
    else
      evt <= next_evt;
  end

  // Error kind is caught with the fatal error and halts the bus until the next reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      error_type_field <= 3'h0;
      bus_halt <= 1'b0;
    end
    else if (sys_error)
    begin
      error_type_field <= sys_error_kind;
      bus_halt <= 1'b1;
    end
  end

  assign normal_summary = |(evt & DBS_NORMAL_SET & ~evt_mask);
  assign abnormal_summary = |(evt & DBS_ABNORMAL_SET & ~evt_mask);
  // State fields are live copies and take no part in the summaries
  always_comb
  begin
    status_word = 32'h00000000;
    status_word[DBS_EVT_W-1:0] = evt;
    status_word[DBS_B_ABN_SUM] = abnormal_summary;
    status_word[DBS_B_NRM_SUM] = normal_summary;
    status_word[DBS_RS_LO +: 3] = rx_state;
    status_word[DBS_TS_LO +: 3] = tx_state;
    status_word[DBS_EB_LO +: 3] = error_type_field;
  end

  // Interrupt follows the summaries one cycle later
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      host_irq <= 1'b0;
    else
      host_irq <= normal_summary || abnormal_summary;
  end

  // Read channel: one read at a time, data one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= DBS_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= DBS_RESP_OKAY;
      if (s_axi_araddr == DBS_RX_BASE_OFS)
        s_axi_rdata <= receive_list_base;
      else if (s_axi_araddr == DBS_TX_BASE_OFS)
        s_axi_rdata <= transmit_list_base;
      else if (s_axi_araddr == DBS_STATUS_OFS)
        s_axi_rdata <= status_word;
      else if (s_axi_araddr == DBS_MASK_OFS)
        s_axi_rdata <= {{(32-DBS_EVT_W){1'b0}}, evt_mask};
      else
      begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= DBS_RESP_DECERR;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Checks; summaries are rebuilt bit by bit so a wrong set constant is caught
  property p_rx_base;
    wr_go && aw_addr == DBS_RX_BASE_OFS && w_strb == 4'hF |=> rx_list_start == $past(w_data[31:2]);
  endproperty
  a_rx_base: assert property (p_rx_base) else $error("receive list start not loaded");
  property p_read_keeps;
    !(wr_go && aw_addr == DBS_STATUS_OFS) && evt_set == '0 && !tx_complete |=> evt == $past(evt);
  endproperty
  a_read_keeps: assert property (p_read_keeps) else $error("event bits changed without cause");
  property p_masked;
    evt_mask == DBS_MASK_RESET |-> !normal_summary && !abnormal_summary;
  endproperty
  a_masked: assert property (p_masked) else $error("masked event reached a summary");
  property p_err_kind;
    sys_error |=> status_word[DBS_EB_LO +: 3] == $past(sys_error_kind) && evt[DBS_B_FATAL] && bus_halt;
  endproperty
  a_err_kind: assert property (p_err_kind) else $error("fatal error not recorded");
  property p_states;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == DBS_STATUS_OFS |=>
      s_axi_rdata[DBS_TS_LO +: 3] == $past(tx_state) && s_axi_rdata[DBS_RS_LO +: 3] == $past(rx_state);
  endproperty
  a_states: assert property (p_states) else $error("process state fields wrong");
  property p_normal;
    normal_summary == |({evt[11], evt[6], evt[2], evt[0]} & ~{evt_mask[11], evt_mask[6], evt_mask[2], evt_mask[0]});
  endproperty
  a_normal: assert property (p_normal) else $error("normal summary wrong");
  property p_abnormal;
    abnormal_summary == |({evt[13], evt[10:7], evt[5], evt[3], evt[1]} &
      ~{evt_mask[13], evt_mask[10:7], evt_mask[5], evt_mask[3], evt_mask[1]});
  endproperty
  a_abnormal: assert property (p_abnormal) else $error("abnormal summary wrong");
  property p_halt_holds;
    bus_halt |=> bus_halt [*3];
  endproperty
  a_halt_holds: assert property (p_halt_holds) else $error("bus halt released");
  property p_timer;
    timer_expired |=> evt[DBS_B_TIMER];
  endproperty
  a_timer: assert property (p_timer) else $error("timer expiry lost");
  property p_early_tx;
    tx_fifo_loaded |=> evt[DBS_B_EARLY_TX];
  endproperty
  a_early_tx: assert property (p_early_tx) else $error("early transmit not set");
  property p_early_clr;
    tx_complete && !tx_fifo_loaded |=> !evt[DBS_B_EARLY_TX] && evt[DBS_B_TX_DONE];
  endproperty
  a_early_clr: assert property (p_early_clr) else $error("early transmit not cleared");
  property p_rx_stop;
    rx_state == DBS_PROC_STOPPED && $past(rx_state) != DBS_PROC_STOPPED |=> evt[DBS_B_RX_STOP];
  endproperty
  a_rx_stop: assert property (p_rx_stop) else $error("receive stop not flagged");
  property p_ru_once;
    rx_desc_host_owned && !rx_prev_dev_owned && !evt[DBS_B_RX_BUF] |=> !evt[DBS_B_RX_BUF];
  endproperty
  a_ru_once: assert property (p_ru_once) else $error("buffer unavailable raised again");
  property p_poll_empty;
    tx_poll_empty && !evt[DBS_B_TX_BUF] |=> !evt[DBS_B_TX_BUF];
  endproperty
  a_poll_empty: assert property (p_poll_empty) else $error("poll demand set buffer unavailable");
  property p_irq;
    (normal_summary || abnormal_summary) ##1 (normal_summary || abnormal_summary) |-> host_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");
  c_rx_base_write: cover property (wr_go && aw_addr == DBS_RX_BASE_OFS);
  c_status_clear: cover property (wr_go && aw_addr == DBS_STATUS_OFS);
  c_irq_rise: cover property ($rose(host_irq));
  c_fatal: cover property (sys_error ##1 bus_halt);
endmodule

// ---- testbench/dbs_host_model.sv ----
// Host-side AXI4-Lite master model that issues single register accesses
`timescale 1ns/1ns
module dbs_host_model
(
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // Idle bus from time zero
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  // One write; released payload is inverted so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready)
      begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (!w_ok && s_axi_wready)
      begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
    while (!s_axi_bvalid)
      @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // One read; rready held until the answer is sampled
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
      @(posedge aclk);
    while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    while (!s_axi_rvalid)
      @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench for the list base and event status register bank
`timescale 1ns/1ns
module tb;
  import dbs_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [13:0] ev = 14'h0000;
  logic [2:0] kind = 3'h0, tx_state = 3'h0, rx_state = 3'h0;
  logic [31:2] rx_list_start, tx_list_start;
  logic bus_halt, host_irq;
  int err_count = 0, n_tests = 0;
  // Reference model state
  logic [13:0] m_evt = 14'h0000, m_mask = 14'h3FFF;
  logic [2:0] m_kind = 3'h0;
  logic m_prev = 1'b1;
  logic [31:0] rd_d, v, w;
  logic [1:0] rsp;

  always #5 aclk = ~aclk;

  dbs_host_model dbs_host_model_i (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // Spare event slots 4 and 12 carry the poll-empty and device-owned qualifiers
  dbs_regs dbs_regs_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .tx_complete(ev[0]), .tx_stopped(ev[1]), .tx_buf_unavail(ev[2]), .tx_poll_empty(ev[4]),
    .tx_jabber(ev[3]), .tx_underflow(ev[5]), .tx_fifo_loaded(ev[10]), .rx_complete(ev[6]),
    .rx_desc_host_owned(ev[7]), .rx_desc_device_owned(ev[12]), .rx_watchdog(ev[9]),
    .timer_expired(ev[11]), .sys_error(ev[13]), .sys_error_kind(kind), .tx_state, .rx_state,
    .rx_list_start, .tx_list_start, .bus_halt, .host_irq);

  task automatic chk32(input logic [31:0] g, input logic [31:0] e, input string m);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e, input string m);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %b expected %b", $time, m, g, e);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Error kind only means something while the fatal bit is set
  task automatic st_chk();
    logic [13:0] a;
    dbs_host_model_i.rd(DBS_STATUS_OFS, rd_d, rsp);
    a = m_evt & ~m_mask;
    v = {6'h00, m_evt[13] ? m_kind : rd_d[25:23], tx_state, rx_state, |(a & DBS_NORMAL_SET),
      |(a & DBS_ABNORMAL_SET), 1'b0, m_evt};
    chk32(rd_d, v, "status");
    chk32({30'h0, rsp}, {30'h0, DBS_RESP_OKAY}, "status rresp");
  endtask

  task automatic irq_chk();
    repeat (2) @(posedge aclk);
    #1;
    chk1(host_irq, |(m_evt & ~m_mask & (DBS_NORMAL_SET | DBS_ABNORMAL_SET)), "irq");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    dbs_host_model_i.wr(a, d, 4'hF, rsp);
    chk32({30'h0, rsp}, {30'h0, e}, "bresp");
  endtask

  task automatic clr(input logic [13:0] c);
    wr(DBS_STATUS_OFS, {18'h0, c}, DBS_RESP_OKAY);
    m_evt = m_evt & ~c;
  endtask

  task automatic set_mask(input logic [13:0] m);
    wr(DBS_MASK_OFS, {18'h0, m}, DBS_RESP_OKAY);
    m_mask = m;
  endtask

  // One-cycle event pulse and its effect on the model
  task automatic pulse(input logic [13:0] p);
    logic b7;
    @(posedge aclk);
    ev <= p;
    @(posedge aclk);
    ev <= 14'h0000;
    b7 = p[7] & ~p[12] & m_prev;
    if (p[13])
      m_kind = kind;
    m_evt = (m_evt & ~{3'b000, p[0] & ~p[10], 10'h000}) | (p & 14'h2E6B) | {6'h00, b7, 4'h0, p[2] & ~p[4], 2'b00};
    m_prev = p[12] | (m_prev & ~p[7]);
  endtask

  initial
  begin
    #200000;
    err_count++;
    conclude();
  end

  initial
  begin
    void'($urandom(88));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    dbs_host_model_i.rd(DBS_MASK_OFS, rd_d, rsp);
    chk32(rd_d, 32'h00003FFF, "mask reset");
    st_chk();
    chk32({rx_list_start, tx_list_start, bus_halt, host_irq}, 62'h0, "reset outputs");
    $display("test reset done");
    // Bases loaded while both processes stopped, then the receive process started
    v = $urandom & 32'hFFFFFFFC;
    wr(DBS_RX_BASE_OFS, v, DBS_RESP_OKAY);
    dbs_host_model_i.rd(DBS_RX_BASE_OFS, rd_d, rsp);
    chk32(rd_d, v, "rx base");
    chk32({rx_list_start, 2'b00}, v, "rx start");
    w = $urandom & 32'hFFFFFFFC;
    wr(DBS_TX_BASE_OFS, w, DBS_RESP_OKAY);
    dbs_host_model_i.wr(DBS_TX_BASE_OFS, ~w, 4'b0110, rsp);
    chk32({30'h0, rsp}, {30'h0, DBS_RESP_OKAY}, "strobed bresp");
    chk32({tx_list_start, 2'b00}, {w[31:24], ~w[23:8], w[7:0]}, "tx start");
    rx_state <= 3'($urandom_range(7, 1));
    $display("test bases done");
    dbs_host_model_i.rd(8'h30, rd_d, rsp);
    chk32({rd_d[29:0], rsp}, {30'h0, DBS_RESP_DECERR}, "unmapped read");
    wr(8'h04, 32'hFFFFFFFF, DBS_RESP_DECERR);
    $display("test unmapped done");
    // Every event except receive stop (bit 8) and fatal (bit 13) alone, first unmasked, then under a random mask
    for (int p = 0; p < 2; p++)
    begin
      set_mask(p ? 14'($urandom) : 14'h0000);
      for (int i = 0; i < 13; i++)
      begin
        if (DBS_EVT_USED[i] && i != 8)
        begin
          tx_state <= 3'($urandom);
          pulse(14'h0001 << i);
          st_chk();
          irq_chk();
          clr(14'h0001 << i);
          st_chk();
          irq_chk();
        end
      end
    end
    $display("test events done");
    set_mask(14'h0000);
    pulse(14'h0400);
    pulse(14'h0001);
    st_chk();
    pulse(14'h0401);
    st_chk();
    pulse(14'h0014);
    st_chk();
    clr(14'h3FFF);
    pulse(14'h1000);
    pulse(14'h0080);
    st_chk();
    clr(14'h0080);
    pulse(14'h0080);
    st_chk();
    rx_state <= 3'h0;
    repeat (2) @(posedge aclk);
    m_evt[8] = 1'b1;
    st_chk();
    rx_state <= 3'h5;
    $display("test special events done");
    // Event lands in the very cycle its clear is written
    pulse(14'h0800);
    fork
      dbs_host_model_i.wr(DBS_STATUS_OFS, 32'h00000800, 4'hF, rsp);
      begin
        repeat (2) @(posedge aclk);
        ev <= 14'h0800;
        @(posedge aclk);
        ev <= 14'h0000;
      end
    join
    st_chk();
    $display("test set wins done");
    kind <= 3'($urandom);
    pulse(14'h2000);
    st_chk();
    chk1(bus_halt, 1'b1, "halt");
    clr(14'h2000);
    st_chk();
    chk1(bus_halt, 1'b1, "halt sticky");
    $display("test fatal done");
    // Second reset in mid-run
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    {m_evt, m_mask, m_prev} = {14'h0000, 14'h3FFF, 1'b1};
    @(posedge aclk);
    chk1(bus_halt | host_irq, 1'b0, "after reset");
    chk1(|{rx_list_start, tx_list_start}, 1'b0, "list starts after reset");
    st_chk();
    $display("test second reset done");
    conclude();
  end
endmodule
